// >>> logic/sfcp_flash_front.sv
/*
 * Instruction front end and write protection of a serial NOR flash.
 * Assumes a host that owns spi_clk and cs_n, and a bench that pulses
 * hw_reset_n low once at start so the link-side flops are defined.
 */
// What this block does
// R1: Capture single-lane input bits on rising clock.
// R2: Drive serial output changes on falling clock.
// R3: Support SPI modes zero and three only.
// R4: Dual reads drive two bidirectional lanes.
// R5: Quad reads drive four bidirectional lanes.
// R6: Reset pair 66h 99h, then ignore commands.
// R7: Hardware reset pulse returns power-on state.
// R8: Hardware reset overrides select, clock, lanes.
// R9: No commands in reset, no writes early.
// R10: Write-enable latch starts cleared after power-up.
// R11: Writes need write-enable latch set first; 39h unlock clears a lock without it.
// R12: Latch clears on disable and op completion.
// R13: Latch reads as S1, set by enable.
// R14: Deep power-down accepts only release command.
// R15: Per-region lock bits block program, erase.
// R16: Locks power up set; 39h clears one.
// R17: Scheme bit picks block-protect or locks.
// R18: Busy bit S0 high during write operations.
// R19: Busy ignores all but status read.
// R20: Block-protect field at S4..S2, writable.
// R21: Top/bottom bit chooses protected array end.
// R22: Protect pin with status-protect gates writes.
// R23: Four-lane enable turns pins into lanes.
// R24: No command before first select rise; started_r sets one clock after srst, as the select flops reset high.
// R25: Hold tri-states output and freezes input.
// R26: First eight bits are opcode, MSB first.
`timescale 1ns/1ps
module sfcp_flash_front
	import sfcp_pkg::*;
#(
	parameter int SW_RESET_CYCLES = SW_RESET_CYC,
	parameter int POWERUP_WRITE_CYCLES = 1000,
	parameter int OP_BUSY_CYCLES = 64
) (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Serial link pins
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic hw_reset_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n
);

	generate
		if (SW_RESET_CYCLES < 2 || SW_RESET_CYCLES > 65535 ||
			POWERUP_WRITE_CYCLES < 1 || POWERUP_WRITE_CYCLES > 65535 ||
			OP_BUSY_CYCLES < 2 || OP_BUSY_CYCLES > 65535) begin : g_bad
			$error("sfcp_flash_front: cycle parameter out of range");
		end
	endgenerate

	function automatic logic [5:0] sfcp_cmd_len(input logic [7:0] opc);
		case (opc)
			OPC_PROG, OPC_SE, OPC_BE, OPC_UNLOCK: sfcp_cmd_len = LEN_ADDR;
			OPC_WRSR1, OPC_WRSR2, OPC_WRSR3: sfcp_cmd_len = LEN_DATA;
			default: sfcp_cmd_len = LEN_OPC;
		endcase
	endfunction

	// ---------------- Link domain ----------------
	logic lnk_rst;
	logic serial_in;
	logic hold_act;
	logic [5:0] cnt_r;
	logic [2:0] ph_r;
	logic [31:0] sh_r;
	logic [7:0] opc_r;
	logic [7:0] cur_opc;
	logic ev_tgl_r;
	sfcp_cmd_t ev_cmd_r;
	logic [24:0] st_vec_r;
	logic [24:0] st_m_r;
	logic [24:0] st_l_r;
	logic [7:0] stat_byte;
	logic dat_bit;

	// Select high or the reset pin low clears the frame at once.
	// R8: reset pin priority
	assign lnk_rst = cs_n | ~hw_reset_n;
	assign serial_in = io_in[0];
	// R25: hold freezes frame
	assign hold_act = ~st_l_r[8 + SR2_QE] & ~io_in[3];
	// R26: opcode MSB first
	assign cur_opc = (cnt_r == 6'h07) ? {sh_r[6:0], serial_in} : opc_r;

	// R1: rising edge capture
	always_ff @(posedge spi_clk or posedge lnk_rst) begin
		if (lnk_rst) begin
			cnt_r <= 6'h00;
			ph_r <= 3'h0;
			sh_r <= 32'h0000_0000;
			opc_r <= 8'h00;
		end else if (!hold_act) begin
			sh_r <= {sh_r[30:0], serial_in};
			ph_r <= ph_r + 3'h1;
			if (cnt_r != 6'h3F) begin
				cnt_r <= cnt_r + 6'h01;
			end
			if (cnt_r == 6'h07) begin
				opc_r <= cur_opc;
			end
		end
	end

	// A complete instruction toggles the event; the word stays stable
	// until the next frame completes, well after the system side took it.
	always_ff @(posedge spi_clk or negedge hw_reset_n) begin
		if (!hw_reset_n) begin
			ev_tgl_r <= 1'b0;
			ev_cmd_r <= '0;
		end else if (!cs_n && !hold_act &&
			cnt_r + 6'h01 == sfcp_cmd_len(cur_opc)) begin
			ev_tgl_r <= ~ev_tgl_r;
			ev_cmd_r.opc <= cur_opc;
			ev_cmd_r.arg <= {sh_r[22:0], serial_in};
		end
	end

	// Status levels from the system side, two flops each.
	always_ff @(posedge spi_clk or negedge hw_reset_n) begin
		if (!hw_reset_n) begin
			st_m_r <= '0;
			st_l_r <= '0;
		end else begin
			st_m_r <= st_vec_r;
			st_l_r <= st_m_r;
		end
	end

	always_comb begin
		case (opc_r)
			OPC_RDSR2: stat_byte = st_l_r[15:8];
			OPC_RDSR3: stat_byte = st_l_r[23:16];
			default: stat_byte = st_l_r[7:0];
		endcase
		dat_bit = ARRAY_FILL[~ph_r];
	end

	// Mode 3 brings a falling edge before the first rising one; with no
	// opcode yet nothing is driven, so both modes behave alike.
	// R2: falling edge drive
	always_ff @(negedge spi_clk or posedge lnk_rst) begin
		if (lnk_rst) begin
			io_out <= 4'h0;
			io_oe_n <= 4'hF;
		// R3: idle-level agnostic
		end else if (hold_act || st_l_r[24]) begin
			io_out <= 4'h0;
			io_oe_n <= 4'hF;
		end else if ((opc_r == OPC_RDSR1 || opc_r == OPC_RDSR2 ||
			opc_r == OPC_RDSR3) && cnt_r >= LEN_OPC) begin
			io_out <= {2'b00, stat_byte[~ph_r], 1'b0};
			io_oe_n <= 4'b1101;
		end else if (st_l_r[0]) begin
			io_out <= 4'h0;
			io_oe_n <= 4'hF;
		end else if (opc_r == OPC_READ && cnt_r >= LEN_ADDR) begin
			io_out <= {2'b00, dat_bit, 1'b0};
			io_oe_n <= 4'b1101;
		// R4: dual lane drive
		end else if ((opc_r == OPC_DUAL_OUT || opc_r == OPC_DUAL_IO) &&
			cnt_r >= LEN_FAST) begin
			io_out <= {2'b00, dat_bit, dat_bit};
			io_oe_n <= 4'b1100;
		// R5: quad lane drive
		// R23: lanes two and three
		end else if ((opc_r == OPC_QUAD_OUT || opc_r == OPC_QUAD_IO) &&
			st_l_r[8 + SR2_QE] && cnt_r >= LEN_FAST) begin
			io_out <= {4{dat_bit}};
			io_oe_n <= 4'b0000;
		end else begin
			io_out <= 4'h0;
			io_oe_n <= 4'hF;
		end
	end

	// ---------------- System domain ----------------
	logic [2:0] sy_m_r;
	logic [2:0] sy_l_r;
	logic tg_m_r;
	logic tg_l_r;
	logic tgl_d_r;
	logic cmd_v;
	sfcp_cmd_t cmd;
	logic cs_s;
	logic rpin_s;
	logic wp_s;
	logic started_r;
	logic [15:0] hcnt_r;
	logic [15:0] rcnt_r;
	logic [15:0] pcnt_r;
	logic [15:0] bcnt_r;
	logic hrst_fire;
	logic sw_fire;
	logic vol_rst;
	logic rst_wait;
	logic puw_done;
	logic go;
	logic start_op;
	logic op_done;
	logic wel_r;
	logic busy_r;
	logic dpd_r;
	logic arm_r;
	logic [2:0] bp_r;
	logic tb_r;
	logic sec_r;
	logic srp_r;
	logic srl_r;
	logic qe_r;
	logic cmp_r;
	logic wps_r;
	logic [LOCK_BITS-1:0] lock_r;
	logic [7:0] lock_idx;
	logic [6:0] blk;
	logic [7:0] nblk;
	logic bp_hit;
	logic prot;
	logic is_wrsr;
	logic is_arr;
	logic sr_ok;
	sfcp_sr1_t sr1;

	// Pin levels pass two flops; the first flop feeds only the second.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sy_m_r <= 3'h7;
			sy_l_r <= 3'h7;
		end else begin
			sy_m_r <= {io_in[2], hw_reset_n, cs_n};
			sy_l_r <= sy_m_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		tg_m_r <= ev_tgl_r;
		tg_l_r <= tg_m_r;
		tgl_d_r <= tg_l_r;
	end

	assign cs_s = sy_l_r[0];
	assign rpin_s = sy_l_r[1];
	assign wp_s = sy_l_r[2];
	assign cmd_v = tg_l_r ^ tgl_d_r;
	assign cmd = ev_cmd_r;
	assign rst_wait = rcnt_r != 16'h0000;
	assign puw_done = pcnt_r == 16'h0000;
	assign op_done = busy_r && bcnt_r == 16'h0000;
	// R7: pulse length check
	assign hrst_fire = !rpin_s && hcnt_r == 16'(HARD_RESET_CYC - 1);
	assign vol_rst = srst || hrst_fire || sw_fire;

	// R24: first select rise
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			started_r <= 1'b0;
		end else if (cs_s) begin
			started_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst || rpin_s) begin
			hcnt_r <= 16'h0000;
		end else if (hcnt_r != 16'(HARD_RESET_CYC)) begin
			hcnt_r <= hcnt_r + 16'h0001;
		end
	end

	// R9: power-up write delay
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pcnt_r <= 16'(POWERUP_WRITE_CYCLES);
		end else if (!puw_done) begin
			pcnt_r <= pcnt_r - 16'h0001;
		end
	end

	// R19: busy ignores all
	// R14: only release in sleep
	// R6: quiet while resetting
	assign go = cmd_v && started_r && !rst_wait && !busy_r &&
		(!dpd_r || cmd.opc == OPC_RDP);
	assign sw_fire = go && arm_r && cmd.opc == OPC_RST;

	always_ff @(posedge clk_sys) begin
		if (srst || hrst_fire) begin
			rcnt_r <= 16'h0000;
		end else if (sw_fire) begin
			rcnt_r <= 16'(SW_RESET_CYCLES);
		end else if (rst_wait) begin
			rcnt_r <= rcnt_r - 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (vol_rst) begin
			arm_r <= 1'b0;
		end else if (go) begin
			arm_r <= cmd.opc == OPC_RSTEN;
		end
	end

	// Protection decode for the addressed region.
	always_comb begin
		blk = cmd.arg[22:16];
		if (blk == 7'h00) begin
			lock_idx = {4'h0, cmd.arg[15:12]};
		end else if (blk == TOP_BLOCK) begin
			lock_idx = {4'h1, cmd.arg[15:12]};
		end else begin
			lock_idx = {1'b0, blk} + 8'h1F;
		end
		nblk = (bp_r >= 3'h6) ? 8'h80 : 8'(8'h01 << (bp_r + 3'h1));
		// R21: top or bottom
		bp_hit = (bp_r != 3'h0) && (tb_r ? ({1'b0, blk} < nblk) :
			({1'b0, blk} >= 8'h80 - nblk));
		// R17: scheme select
		// R15: locked region refused
		if (cmd.opc == OPC_CE) begin
			prot = wps_r ? |lock_r : (bp_r != 3'h0) || cmp_r;
		end else begin
			prot = wps_r ? lock_r[lock_idx] : bp_hit ^ cmp_r;
		end
		is_wrsr = cmd.opc == OPC_WRSR1 || cmd.opc == OPC_WRSR2 ||
			cmd.opc == OPC_WRSR3;
		is_arr = cmd.opc == OPC_PROG || cmd.opc == OPC_SE ||
			cmd.opc == OPC_BE || cmd.opc == OPC_CE;
		// R22: pin gates status writes
		sr_ok = !srl_r && !(srp_r && !wp_s && !qe_r);
	end

	// R11: latch required
	assign start_op = go && wel_r && puw_done &&
		((is_wrsr && sr_ok) || (is_arr && !prot));

	// R10: cleared at power-up
	// R12: cleared on completion
	// R13: set by enable
	always_ff @(posedge clk_sys) begin
		if (vol_rst || op_done) begin
			wel_r <= 1'b0;
		end else if (go && cmd.opc == OPC_WRDI) begin
			wel_r <= 1'b0;
		end else if (go && cmd.opc == OPC_WREN && puw_done) begin
			wel_r <= 1'b1;
		end
	end

	// R18: busy during operation
	always_ff @(posedge clk_sys) begin
		if (vol_rst) begin
			busy_r <= 1'b0;
			bcnt_r <= 16'h0000;
		end else if (start_op) begin
			busy_r <= 1'b1;
			bcnt_r <= 16'(OP_BUSY_CYCLES - 1);
		end else if (op_done) begin
			busy_r <= 1'b0;
		end else if (busy_r) begin
			bcnt_r <= bcnt_r - 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (vol_rst) begin
			dpd_r <= 1'b0;
		end else if (go && cmd.opc == OPC_DPD) begin
			dpd_r <= 1'b1;
		end else if (go && cmd.opc == OPC_RDP) begin
			dpd_r <= 1'b0;
		end
	end

	// Non-volatile bits survive the pin and software resets.
	// R20: block-protect write
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			{srp_r, sec_r, tb_r, bp_r} <= SR_RST[7:2];
			{cmp_r, qe_r, srl_r} <= {SR_RST[SR2_CMP], SR_RST[SR2_QE],
				SR_RST[SR2_SRL]};
			wps_r <= SR_RST[SR3_WPS];
		end else if (start_op && cmd.opc == OPC_WRSR1) begin
			{srp_r, sec_r, tb_r, bp_r} <= cmd.arg[7:2];
		end else if (start_op && cmd.opc == OPC_WRSR2) begin
			cmp_r <= cmd.arg[SR2_CMP];
			qe_r <= cmd.arg[SR2_QE];
			srl_r <= cmd.arg[SR2_SRL];
		end else if (start_op && cmd.opc == OPC_WRSR3) begin
			wps_r <= cmd.arg[SR3_WPS];
		end
	end

	// R16: locks set, unlock clears
	generate
		for (genvar i = 0; i < LOCK_BITS; i++) begin : g_lock
			always_ff @(posedge clk_sys) begin
				if (vol_rst) begin
					lock_r[i] <= 1'b1;
				end else if (go && cmd.opc == OPC_UNLOCK &&
					lock_idx == 8'(i)) begin
					lock_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		sr1.status_protect_select = srp_r;
		sr1.sec = sec_r;
		sr1.tb = tb_r;
		sr1.bp = bp_r;
		sr1.write_enable_latch = wel_r;
		sr1.busy = busy_r;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_vec_r <= {1'b1, 24'h00_0000};
		end else begin
			st_vec_r <= {dpd_r || rst_wait || !started_r,
				5'h00, wps_r, 2'b00, 1'b0, cmp_r, 4'h0, qe_r, srl_r,
				sr1};
		end
	end

	// ---------------- Checks ----------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	property p_wel_set;
		go && cmd.opc == OPC_WREN && puw_done && !vol_rst |=> wel_r;
	endproperty
	a_wel_set: assert property (p_wel_set) // R13
		else $error("enable did not set latch");

	property p_wel_done;
		op_done |=> !wel_r && !busy_r;
	endproperty
	a_wel_done: assert property (p_wel_done) // R12
		else $error("latch or busy survived completion");

	property p_busy_wel;
		$rose(busy_r) |-> $past(wel_r) && $past(puw_done);
	endproperty
	a_busy_wel: assert property (p_busy_wel) // R11
		else $error("operation started without latch");

	property p_busy_hold;
		start_op && !vol_rst |=> busy_r [*2];
	endproperty
	a_busy_hold: assert property (p_busy_hold) // R18
		else $error("busy not held during operation");

	property p_busy_ignore;
		busy_r && bcnt_r > 16'h0001 && cmd_v && !vol_rst |=>
			busy_r && $stable(bp_r) && $stable(lock_r) && $stable(dpd_r);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) // R19
		else $error("instruction acted on while busy");

	property p_dpd_ignore;
		dpd_r && cmd_v && cmd.opc != OPC_RDP && !vol_rst |=>
			dpd_r && $stable(wel_r) && !busy_r;
	endproperty
	a_dpd_ignore: assert property (p_dpd_ignore) // R14
		else $error("instruction acted on in power-down");

	property p_hrst;
		hrst_fire |=> !wel_r && !busy_r && !dpd_r && (&lock_r);
	endproperty
	a_hrst: assert property (p_hrst) // R7
		else $error("pin reset did not restore power-on state");

	sequence s_low_run;
		(!rpin_s && hcnt_r < 16'(HARD_RESET_CYC - 1)) [*1];
	endsequence
	property p_hrst_short;
		s_low_run |-> !vol_rst || srst || sw_fire;
	endproperty
	a_hrst_short: assert property (p_hrst_short) // R7
		else $error("pin reset acted too early");

	property p_swrst;
		sw_fire |=> rst_wait && !wel_r ##1 rst_wait;
	endproperty
	a_swrst: assert property (p_swrst) // R6
		else $error("software reset did not hold off");

	property p_puw;
		!puw_done && cmd_v |=> !wel_r && !busy_r;
	endproperty
	a_puw: assert property (p_puw) // R9
		else $error("write accepted in power-up delay");

	property p_unlock;
		go && cmd.opc == OPC_UNLOCK && !vol_rst |=>
			!lock_r[$past(lock_idx)];
	endproperty
	a_unlock: assert property (p_unlock) // R16
		else $error("unlock did not clear lock");

	property p_start;
		!started_r && cmd_v |=> $stable(wel_r) && $stable(dpd_r);
	endproperty
	a_start: assert property (p_start) // R24
		else $error("instruction accepted before select rise");

	c_prog: cover property (go && cmd.opc == OPC_PROG && start_op);
	c_swrst: cover property (sw_fire);
	c_unlock: cover property (go && cmd.opc == OPC_UNLOCK);
	c_dpd: cover property ($fell(dpd_r));

endmodule

// >>> pkg/sfcp_pkg.sv
/*
 * Constants and carrier types for the serial flash command and
 * protection front end. Assumes a 250 MHz system clock.
 */
package sfcp_pkg;

	// System clock period in picoseconds.
	localparam int SYS_CLK_PS = 4000;
	// Software reset recovery time, and the least hardware reset pulse.
	localparam int SW_RESET_US = 30;
	localparam int SW_RESET_CYC = (SW_RESET_US * 1000000) / SYS_CLK_PS;
	localparam int HARD_RESET_MIN_US = 1;
	localparam int HARD_RESET_CYC =
		(HARD_RESET_MIN_US * 1000000 + SYS_CLK_PS - 1) / SYS_CLK_PS;

	// Instruction opcodes.
	localparam logic [7:0] OPC_WREN = 8'h06;
	localparam logic [7:0] OPC_WRDI = 8'h04;
	localparam logic [7:0] OPC_RDSR1 = 8'h05;
	localparam logic [7:0] OPC_RDSR2 = 8'h35;
	localparam logic [7:0] OPC_RDSR3 = 8'h15;
	localparam logic [7:0] OPC_WRSR1 = 8'h01;
	localparam logic [7:0] OPC_WRSR2 = 8'h31;
	localparam logic [7:0] OPC_WRSR3 = 8'h11;
	localparam logic [7:0] OPC_READ = 8'h03;
	localparam logic [7:0] OPC_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OPC_DUAL_IO = 8'hBB;
	localparam logic [7:0] OPC_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OPC_QUAD_IO = 8'hEB;
	localparam logic [7:0] OPC_PROG = 8'h02;
	localparam logic [7:0] OPC_SE = 8'h20;
	localparam logic [7:0] OPC_BE = 8'hD8;
	localparam logic [7:0] OPC_CE = 8'hC7;
	localparam logic [7:0] OPC_UNLOCK = 8'h39;
	localparam logic [7:0] OPC_DPD = 8'hB9;
	localparam logic [7:0] OPC_RDP = 8'hAB;
	localparam logic [7:0] OPC_RSTEN = 8'h66;
	localparam logic [7:0] OPC_RST = 8'h99;

	// Frame lengths in bits: opcode, opcode+data, opcode+address, +dummy.
	localparam logic [5:0] LEN_OPC = 6'h08;
	localparam logic [5:0] LEN_DATA = 6'h10;
	localparam logic [5:0] LEN_ADDR = 6'h20;
	localparam logic [5:0] LEN_FAST = 6'h28;

	// Status field positions inside registers two and three.
	localparam int SR2_SRL = 0;
	localparam int SR2_QE = 1;
	localparam int SR2_CMP = 6;
	localparam int SR3_WPS = 2;
	localparam logic [7:0] SR_RST = 8'h00;

	// Individual lock layout.
	localparam int LOCK_INTERIOR = 126;
	localparam int LOCK_SECTORS = 32;
	localparam int LOCK_BITS = LOCK_INTERIOR + LOCK_SECTORS;
	localparam logic [6:0] TOP_BLOCK = 7'h7F;
	// Value shown for array data, which this block does not store.
	localparam logic [7:0] ARRAY_FILL = 8'hFF;

	typedef struct packed {
		logic [7:0] opc;
		logic [23:0] arg;
	} sfcp_cmd_t;

	typedef struct packed {
		logic status_protect_select;
		logic sec;
		logic tb;
		logic [2:0] bp;
		logic write_enable_latch;
		logic busy;
	} sfcp_sr1_t;

endpackage

// >>> tb/sfcp_host_model.sv
/*
 * Behavioural host controller for the serial flash front end.
 * Assumes the bench resolves the shared lanes from the output enables.
 */
`timescale 1ns/1ps
module sfcp_host_model (
	// Link pins
	output logic spi_clk,
	output logic cs_n,
	output logic host_d0,
	// Lanes seen from the device
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n
);
	// Clock idle level: 0 for mode zero, 1 for mode three.
	logic mode3;

	// Select rises once just after start, so the link flops clear.
	// select starts low
	initial begin
		mode3 = 1'b0;
		spi_clk = 1'b0;
		cs_n = 1'b0;
		host_d0 = 1'b0;
		#1 cs_n = 1'b1;
	end

	task automatic frame(input logic [39:0] tx, input int ntx,
		input int nrx, output logic [7:0] rx, output logic [3:0] oe);
		rx = 8'h00;
		oe = 4'hF;
		spi_clk = mode3;
		#10 cs_n = 1'b0;
		for (int i = 0; i < ntx + nrx; i++) begin
			spi_clk = 1'b0;
			// A released input toggles so a stale level is never read.
			if (i < ntx)
				host_d0 = tx[39 - i];
			else
				host_d0 = ~host_d0;
			#24 spi_clk = 1'b1;
			if (i >= ntx) begin
				rx = {rx[6:0], io_out[1]};
				oe = io_oe_n;
			end
			#24;
		end
		spi_clk = mode3;
		#10 cs_n = 1'b1;
		#100;
	endtask
endmodule

// >>> tb/serial_flash_command_protect_tb_top.sv
/*
 * Self-checking bench for the serial flash front end.
 * Assumes the host model above and short parameter values.
 */
`timescale 1ns/1ps
module serial_flash_command_protect_tb_top
	import sfcp_pkg::*;
;
	localparam int PUW = 200;
	localparam int SWR = 400;
	localparam int BUSY = 500;

	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic hw_reset_n = 1'b1;
	logic wp_n = 1'b1;
	logic hold_n = 1'b1;
	logic spi_clk;
	logic cs_n;
	logic host_d0;
	logic [3:0] io_in;
	logic [3:0] io_out;
	logic [3:0] io_oe_n;
	int err_count = 0;
	int n_tests = 0;
	logic [7:0] v;
	logic [3:0] o;

	always #2 clk_sys = ~clk_sys;

	// Each lane is the device when it drives, else host or pull-up.
	assign io_in[0] = !io_oe_n[0] ? io_out[0] : host_d0;
	assign io_in[1] = !io_oe_n[1] ? io_out[1] : ~host_d0;
	assign io_in[2] = !io_oe_n[2] ? io_out[2] : wp_n;
	assign io_in[3] = !io_oe_n[3] ? io_out[3] : hold_n;

	sfcp_flash_front #(
		.SW_RESET_CYCLES(SWR),
		.POWERUP_WRITE_CYCLES(PUW),
		.OP_BUSY_CYCLES(BUSY)
	) i_sfcp_flash_front (
		.clk_sys(clk_sys),
		.srst(srst),
		.spi_clk(spi_clk),
		.cs_n(cs_n),
		.hw_reset_n(hw_reset_n),
		.io_in(io_in),
		.io_out(io_out),
		.io_oe_n(io_oe_n)
	);

	sfcp_host_model i_sfcp_host_model (
		.spi_clk(spi_clk),
		.cs_n(cs_n),
		.host_d0(host_d0),
		.io_out(io_out),
		.io_oe_n(io_oe_n)
	);

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic cmd(input logic [39:0] tx, input int n);
		logic [7:0] r;
		logic [3:0] e;
		i_sfcp_host_model.frame(tx, n, 0, r, e);
	endtask

	// Reads one status register, compares the masked byte and the enable.
	task automatic rs(input logic [7:0] opc, input logic [7:0] exp,
		input logic [7:0] mask);
		logic [7:0] r;
		logic [3:0] e;
		i_sfcp_host_model.frame({opc, 32'h0000_0000}, 8, 8, r, e);
		check("status", r & mask, exp);
		check("status_enable", {4'h0, e}, 8'h0D);
	endtask

	// Reads and expects the device to leave every lane released.
	task automatic quiet();
		i_sfcp_host_model.frame({OPC_RDSR1, 32'h0000_0000}, 8, 8, v, o);
		check("released", {4'h0, o}, 8'h0F);
	endtask

	task automatic wren();
		cmd({OPC_WREN, 32'h0000_0000}, 8);
	endtask

	task automatic wrsr(input logic [7:0] opc, input logic [7:0] d);
		wren();
		cmd({opc, d, 24'h00_0000}, 16);
	endtask

	task automatic fast(input logic [7:0] opc, input logic [3:0] exp_oe);
		i_sfcp_host_model.frame({opc, 32'h0000_0000}, 40, 8, v, o);
		check("lane_enable", {4'h0, o}, {4'h0, exp_oe});
		if (exp_oe != 4'hF)
			check("array_data", v, ARRAY_FILL);
	endtask

	initial begin
		repeat (100000) @(posedge clk_sys);
		err_count++;
		report_and_stop();
	end

	initial begin
		// The pin pulse starts after time zero so its edge is seen.
		@(negedge clk_sys) hw_reset_n = 1'b0;
		cyc(10);
		hw_reset_n = 1'b1;
		cyc(10);
		srst = 1'b0;
		cyc(5);
		wren();
		rs(OPC_RDSR1, 8'h00, 8'hFF);
		cyc(PUW);
		wren();
		rs(OPC_RDSR1, 8'h02, 8'hFF);
		cmd({OPC_WRDI, 32'h0000_0000}, 8);
		rs(OPC_RDSR1, 8'h00, 8'hFF);
		cmd({OPC_PROG, 32'h0000_0000}, 32);
		rs(OPC_RDSR1, 8'h00, 8'hFF);
		wrsr(OPC_WRSR1, 8'h34);
		rs(OPC_RDSR1, 8'h37, 8'hFF);
		cmd({OPC_DPD, 32'h0000_0000}, 8);
		cyc(BUSY);
		rs(OPC_RDSR1, 8'h34, 8'hFF);
		// Bottom blocks are protected, top blocks are free.
		wren();
		cmd({OPC_PROG, 32'h7000_0000}, 32);
		rs(OPC_RDSR1, 8'h37, 8'hFF);
		cyc(BUSY);
		wren();
		cmd({OPC_PROG, 32'h1000_0000}, 32);
		rs(OPC_RDSR1, 8'h36, 8'hFF);
		wrsr(OPC_WRSR3, 8'h04);
		cyc(BUSY);
		rs(OPC_RDSR3, 8'h04, 8'h04);
		wren();
		cmd({OPC_PROG, 32'h7000_0000}, 32);
		rs(OPC_RDSR1, 8'h36, 8'hFF);
		cmd({OPC_UNLOCK, 32'h7000_0000}, 32);
		cmd({OPC_PROG, 32'h7000_0000}, 32);
		rs(OPC_RDSR1, 8'h37, 8'hFF);
		cyc(BUSY);
		wrsr(OPC_WRSR1, 8'hB4);
		cyc(BUSY);
		rs(OPC_RDSR1, 8'hB4, 8'hFF);
		@(negedge clk_sys) wp_n = 1'b0;
		wrsr(OPC_WRSR1, 8'h80);
		cyc(BUSY);
		rs(OPC_RDSR1, 8'hB4, 8'hFD);
		@(negedge clk_sys) wp_n = 1'b1;
		wrsr(OPC_WRSR1, 8'h80);
		cyc(BUSY);
		rs(OPC_RDSR1, 8'h80, 8'hFF);
		@(negedge clk_sys) hold_n = 1'b0;
		quiet();
		@(negedge clk_sys) hold_n = 1'b1;
		fast(OPC_DUAL_OUT, 4'hC);
		fast(OPC_DUAL_IO, 4'hC);
		fast(OPC_QUAD_OUT, 4'hF);
		wrsr(OPC_WRSR2, 8'h02);
		cyc(BUSY);
		rs(OPC_RDSR2, 8'h02, 8'hFF);
		fast(OPC_QUAD_OUT, 4'h0);
		fast(OPC_QUAD_IO, 4'h0);
		i_sfcp_host_model.frame({OPC_READ, 32'h0000_0000}, 32, 8, v, o);
		check("read_data", v, ARRAY_FILL);
		check("read_enable", {4'h0, o}, 8'h0D);
		i_sfcp_host_model.mode3 = 1'b1;
		rs(OPC_RDSR1, 8'h80, 8'hFF);
		i_sfcp_host_model.mode3 = 1'b0;
		cmd({OPC_DPD, 32'h0000_0000}, 8);
		wren();
		quiet();
		cmd({OPC_RDP, 32'h0000_0000}, 8);
		rs(OPC_RDSR1, 8'h80, 8'hFF);
		wren();
		cmd({OPC_RSTEN, 32'h0000_0000}, 8);
		cmd({OPC_RST, 32'h0000_0000}, 8);
		quiet();
		cyc(SWR);
		rs(OPC_RDSR1, 8'h00, 8'h03);
		wren();
		@(negedge clk_sys) hw_reset_n = 1'b0;
		cyc(260);
		hw_reset_n = 1'b1;
		cyc(10);
		rs(OPC_RDSR1, 8'h80, 8'hFF);
		wren();
		cmd({OPC_PROG, 32'h7000_0000}, 32);
		rs(OPC_RDSR1, 8'h82, 8'hFF);
		cmd({OPC_CE, 32'h0000_0000}, 8);
		rs(OPC_RDSR1, 8'h82, 8'hFF);
		cmd({OPC_UNLOCK, 32'h7000_0000}, 32);
		cmd({OPC_SE, 32'h7000_0000}, 32);
		rs(OPC_RDSR1, 8'h83, 8'hFF);
		report_and_stop();
	end
endmodule
